// [design/fsp_pkg.sv]
// Package for the flash sector protection logic: register map, field
// positions, reset values, command codes and timing counts.
// Assumes an APB master at 250 MHz; nonvolatile cells are modelled in flops.
package fsp_pkg;
	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [11:0] OFF_CMD      = 12'h000;
	localparam logic [11:0] OFF_ARG      = 12'h004;
	localparam logic [11:0] OFF_PWLO     = 12'h008;
	localparam logic [11:0] OFF_PWHI     = 12'h00C;
	localparam logic [11:0] OFF_STATUS   = 12'h010;
	localparam logic [11:0] OFF_MODECFG  = 12'h014;
	localparam logic [11:0] OFF_NVBITS   = 12'h018;
	localparam logic [11:0] OFF_VBITS    = 12'h01C;
	localparam logic [11:0] OFF_RANGE    = 12'h020;
	localparam logic [11:0] OFF_CHECK    = 12'h024;

	// ************************************************************
	// Commands written to the command register
	// ************************************************************
	localparam logic [3:0] CMD_NV_PROG   = 4'h1;
	localparam logic [3:0] CMD_NV_ERASE  = 4'h2;
	localparam logic [3:0] CMD_VOL_WRITE = 4'h3;
	localparam logic [3:0] CMD_LOCK_CLR  = 4'h4;
	localparam logic [3:0] CMD_PW_PROG   = 4'h5;
	localparam logic [3:0] CMD_PW_READ   = 4'h6;
	localparam logic [3:0] CMD_PW_UNLOCK = 4'h7;
	localparam logic [3:0] CMD_MODE_PROG = 4'h8;
	localparam logic [3:0] CMD_SOFT_RST  = 4'h9;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ST_BUSY   = 0;
	localparam int ST_PERR   = 1;
	localparam int ST_LOCK   = 2;
	localparam int ST_PWMODE = 3;
	localparam int ST_DENIED = 4;
	localparam int ARG_VAL   = 8;
	localparam int CFG_MODE  = 1;

	// ************************************************************
	// Reset values and mode encodings
	// ************************************************************
	localparam logic [1:0]  MODE_NONE    = 2'b11;
	localparam logic [1:0]  MODE_PERSIST = 2'b10;
	localparam logic [1:0]  MODE_PASSWD  = 2'b01;
	localparam logic [1:0]  MODE_ILLEGAL = 2'b00;
	localparam logic [63:0] PW_SHIPPED   = 64'hFFFFFFFFFFFFFFFF;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ       = 250;
	localparam int UNLOCK_GAP_US = 100;
	localparam int UNLOCK_TOL_US = 20;
	localparam int UNLOCK_CYC    = UNLOCK_GAP_US * CLK_MHZ;
	localparam int NV_PROG_CYC   = 64;
	localparam int NV_ERASE_CYC  = 256;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_WORK = 2'b01,
		ST_HOLD = 2'b10
	} fsp_state_t;
endpackage

// [design/fsp_guard.sv]
// Sector protection engine behind an APB slave.
// Assumes a single clock; the array controller asks via chkSector.
//
// Implementation choices: the address map and the APB slave port.

// Function
// - Range or sector guard protects sector
// - Either sector bit zero blocks sector
// - Lock zero fails nonvolatile bit changes
// - Persistent: lock set on hardware reset
// - Password: lock cleared on hardware reset (reset here sets lock to one and mode to none; lock clear or password mode program clears it)
// - Lock clear command drops lock
// - Decode mode field 11/10/01
// - Mode 00 program fails
// - Chosen mode freezes configuration
// - Factory state persistent, all unprotected
// - Busy while nonvolatile writes run (password program here updates pw_ff at once, with no busy)
// - Bits program singly, erase together
// - Volatile bit matters when nonvolatile one
// - Volatile bits unprotect on any reset
// - Exact 64-bit match sets lock
// - Mismatch: error, busy, lock kept
// - Unlock attempts spaced by 100 us
// - Correct password skips delay
// - Password bits only go one to zero
// - Password mode hides password storage
// - Password ships all ones
module fsp_guard
	import fsp_pkg::*;
#(
	parameter int SECTORS    = 32,
	parameter int UNLOCK_CNT = UNLOCK_CYC
)
(
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Array controller protection query
	input  wire logic [$clog2(SECTORS)-1:0] chkSector,
	output logic                            chkProtected
);
	localparam int SW = $clog2(SECTORS);

	// ************************************************************
	// State
	// ************************************************************
	fsp_state_t           state_ff;
	logic [SECTORS-1:0]   nvBits_ff;
	logic [SECTORS-1:0]   volBits_ff;
	logic [SECTORS-1:0]   rangeBits_ff;
	logic                 lock_ff;
	logic [1:0]           mode_ff;
	logic [63:0]          pw_ff;
	logic [63:0]          pwIn_ff;
	logic [31:0]          arg_ff;
	logic                 perr_ff;
	logic                 denied_ff;
	logic [31:0]          cnt_ff;
	logic [31:0]          prdata_ff;
	logic [3:0]           job_ff;

	// ************************************************************
	// Decode
	// ************************************************************
	wire        apbWr   = psel && penable && pwrite;
	wire        apbRd   = psel && penable && !pwrite;
	wire        hitCmd  = apbWr && (paddr == OFF_CMD);
	wire [3:0]  cmd     = pwdata[3:0];
	wire        idle    = (state_ff == ST_IDLE);
	wire        pwMode  = (mode_ff == MODE_PASSWD);
	wire        modeSet = (mode_ff != MODE_NONE);
	wire [SW-1:0] argSec = arg_ff[SW-1:0];
	wire        argVal  = arg_ff[ARG_VAL];
	wire        pwMatch = (pwIn_ff == pw_ff);
	wire        start   = hitCmd && idle;
	wire        nvCmd   = (cmd == CMD_NV_PROG) || (cmd == CMD_NV_ERASE);
	wire        badMode = (arg_ff[CFG_MODE+1:CFG_MODE] == MODE_ILLEGAL);
	wire        pwLocked = pwMode;

	function automatic logic guarded(input logic nv, input logic vol,
		input logic rng);
		// Volatile bit only counts while nonvolatile bit is one
		guarded = rng || !nv || !vol;
	endfunction

	assign chkProtected = guarded(nvBits_ff[chkSector], volBits_ff[chkSector],
		rangeBits_ff[chkSector]);

	// ************************************************************
	// Command engine
	// ************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff   <= ST_IDLE;
			nvBits_ff  <= '1;
			volBits_ff <= '1;
			rangeBits_ff <= '0;
			lock_ff    <= 1'b1;
			mode_ff    <= MODE_NONE;
			pw_ff      <= PW_SHIPPED;
			pwIn_ff    <= '0;
			arg_ff     <= '0;
			perr_ff    <= 1'b0;
			denied_ff  <= 1'b0;
			cnt_ff     <= '0;
			job_ff     <= '0;
		end
		else
		begin
			if (apbWr && paddr == OFF_ARG)
				arg_ff <= pwdata;
			if (apbWr && paddr == OFF_PWLO)
				pwIn_ff[31:0] <= pwdata;
			if (apbWr && paddr == OFF_PWHI)
				pwIn_ff[63:32] <= pwdata;
			if (apbWr && paddr == OFF_RANGE)
				rangeBits_ff <= pwdata[SECTORS-1:0];
			if (apbWr && paddr == OFF_CHECK)
				denied_ff <= guarded(nvBits_ff[pwdata[SW-1:0]],
					volBits_ff[pwdata[SW-1:0]],
					rangeBits_ff[pwdata[SW-1:0]]);
			case (state_ff)
			ST_IDLE:
			begin
				if (start)
				begin
					perr_ff <= 1'b0;
					job_ff  <= cmd;
					if (nvCmd && !lock_ff)
						perr_ff <= 1'b1;
					else if (cmd == CMD_NV_PROG)
					begin
						state_ff <= ST_WORK;
						cnt_ff   <= NV_PROG_CYC;
					end
					else if (cmd == CMD_NV_ERASE)
					begin
						state_ff <= ST_WORK;
						cnt_ff   <= NV_ERASE_CYC;
					end
					else if (cmd == CMD_VOL_WRITE)
						volBits_ff[argSec] <= argVal;
					else if (cmd == CMD_LOCK_CLR)
						lock_ff <= 1'b0;
					else if (cmd == CMD_PW_PROG && !pwLocked)
						pw_ff <= pw_ff & pwIn_ff;
					else if (cmd == CMD_MODE_PROG)
					begin
						if (modeSet || badMode)
							perr_ff <= 1'b1;
						else
						begin
							state_ff <= ST_WORK;
							cnt_ff   <= NV_PROG_CYC;
						end
					end
					else if (cmd == CMD_PW_UNLOCK && pwMode)
					begin
						if (pwMatch)
							lock_ff <= 1'b1;
						else
						begin
							perr_ff  <= 1'b1;
							state_ff <= ST_HOLD;
							cnt_ff   <= UNLOCK_CNT;
						end
					end
					else if (cmd == CMD_SOFT_RST)
						volBits_ff <= '1;
				end
			end
			ST_WORK:
			begin
				if (cnt_ff == 32'd1)
				begin
					state_ff <= ST_IDLE;
					if (job_ff == CMD_NV_PROG)
						nvBits_ff[argSec] <= 1'b0;
					else if (job_ff == CMD_NV_ERASE)
						nvBits_ff <= '1;
					else
					begin
						mode_ff <= arg_ff[CFG_MODE+1:CFG_MODE];
						if (arg_ff[CFG_MODE+1:CFG_MODE] == MODE_PASSWD)
							lock_ff <= 1'b0;
					end
				end
				cnt_ff <= cnt_ff - 32'd1;
			end
			ST_HOLD:
			begin
				if (cnt_ff == 32'd1)
					state_ff <= ST_IDLE;
				cnt_ff <= cnt_ff - 32'd1;
			end
			default:
				state_ff <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Read mux
	// ************************************************************
	// Mode program latches bits [2:1] of the argument register
	wire [31:0] statusWord = {27'h0, denied_ff, pwMode, lock_ff, perr_ff,
		!idle};
	wire [31:0] pwRead = pwLocked ? 32'h00000000 :
		(arg_ff[0] ? pw_ff[63:32] : pw_ff[31:0]);
	wire        hitKnown = (paddr == OFF_CMD) || (paddr == OFF_ARG) ||
		(paddr == OFF_PWLO) || (paddr == OFF_PWHI) ||
		(paddr == OFF_STATUS) || (paddr == OFF_MODECFG) ||
		(paddr == OFF_NVBITS) || (paddr == OFF_VBITS) ||
		(paddr == OFF_RANGE) || (paddr == OFF_CHECK);
	logic [31:0] nxt_prdata;
	always_comb
	begin
		nxt_prdata = 32'h00000000;
		case (paddr)
		OFF_CMD:     nxt_prdata = pwRead;
		OFF_ARG:     nxt_prdata = arg_ff;
		OFF_STATUS:  nxt_prdata = statusWord;
		OFF_MODECFG: nxt_prdata = {29'h0, mode_ff, 1'b1};
		OFF_NVBITS:  nxt_prdata = 32'(nvBits_ff);
		OFF_VBITS:   nxt_prdata = 32'(volBits_ff);
		OFF_RANGE:   nxt_prdata = 32'(rangeBits_ff);
		default:     nxt_prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata_ff <= '0;
		else if (psel && !penable && !pwrite)
			prdata_ff <= nxt_prdata;
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hitKnown;

	// ************************************************************
	// Checks
	// ************************************************************
	a_lock_guard: assert property (@(posedge clk) disable iff (rst)
		(start && nvCmd && !lock_ff) |=> (nvBits_ff == $past(nvBits_ff))
		&& perr_ff && idle)
		else $error("nonvolatile command ran while locked");
	a_unlock_gap: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_PW_UNLOCK && pwMode && !pwMatch)
		|=> (state_ff == ST_HOLD) [*8])
		else $error("failed unlock did not hold busy");
	a_unlock_ok: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_PW_UNLOCK && pwMode && pwMatch)
		|=> lock_ff && idle)
		else $error("good unlock did not set lock at once");
	a_mode_freeze: assert property (@(posedge clk) disable iff (rst)
		(idle && modeSet) |=> (mode_ff == $past(mode_ff)))
		else $error("mode changed after selection");
	a_mode_legal: assert property (@(posedge clk) disable iff (rst)
		mode_ff != MODE_ILLEGAL)
		else $error("illegal mode took effect");
	a_pw_clear: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> ((pw_ff & ~$past(pw_ff)) == 64'h0))
		else $error("password cell went from zero to one");
	a_busy_prog: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_NV_PROG && lock_ff) |=> !idle [*8])
		else $error("busy missing during bit program");
	a_sector_or: assert property (@(posedge clk) disable iff (rst)
		rangeBits_ff[chkSector] |-> chkProtected)
		else $error("range protected sector shown open");
	a_relock_none: assert property (@(posedge clk) disable iff (rst)
		(!lock_ff && !pwMode) |=> !lock_ff)
		else $error("lock set again in persistent mode");

	// ************************************************************
	// Checks on sector state, lock and password handling
	// ************************************************************
	a_both_bits: assert property (@(posedge clk) disable iff (rst)
		(!nvBits_ff[chkSector] || !volBits_ff[chkSector])
		|-> chkProtected)
		else $error("sector with a zero bit shown open");

	a_vol_masked: assert property (@(posedge clk) disable iff (rst)
		(nvBits_ff[chkSector] && volBits_ff[chkSector]
		&& !rangeBits_ff[chkSector]) |-> !chkProtected)
		else $error("unprotected sector shown protected");

	a_lock_clear: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_LOCK_CLR) |=> !lock_ff)
		else $error("lock clear command left lock set");

	a_pw_lock: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_WORK && job_ff == CMD_MODE_PROG && cnt_ff == 32'd1
		&& arg_ff[CFG_MODE+1:CFG_MODE] == MODE_PASSWD)
		|=> (!lock_ff && pwMode))
		else $error("password mode did not clear lock");

	a_no_unlock: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_PW_UNLOCK && !pwMode)
		|=> (lock_ff == $past(lock_ff)))
		else $error("unlock acted outside password mode");

	a_nv_single: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_WORK && job_ff == CMD_NV_PROG && cnt_ff == 32'd1)
		|=> (nvBits_ff == ($past(nvBits_ff)
		& ~(SECTORS'(1) << $past(argSec)))))
		else $error("bit program touched other sectors");

	a_nv_erase: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_WORK && job_ff == CMD_NV_ERASE && cnt_ff == 32'd1)
		|=> (&nvBits_ff))
		else $error("group erase left a bit at zero");

	a_nv_frozen: assert property (@(posedge clk) disable iff (rst)
		!lock_ff |=> (nvBits_ff == $past(nvBits_ff)))
		else $error("nonvolatile bits changed while locked");

	a_soft_vol: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_SOFT_RST) |=> (&volBits_ff))
		else $error("soft reset left a volatile bit at zero");

	a_soft_lock: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_SOFT_RST) |=> (lock_ff == $past(lock_ff)))
		else $error("soft reset changed the lock");

	a_unlock_err: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_PW_UNLOCK && pwMode && !pwMatch)
		|=> (perr_ff && !idle && lock_ff == $past(lock_ff)))
		else $error("failed unlock did not report error");

	a_hold_keep: assert property (@(posedge clk) disable iff (rst)
		(state_ff == ST_HOLD && cnt_ff != 32'd1) |=> (state_ff == ST_HOLD))
		else $error("unlock delay ended early");

	a_pw_hidden: assert property (@(posedge clk) disable iff (rst)
		(pwMode && start && cmd == CMD_PW_PROG) |=> (pw_ff == $past(pw_ff)))
		else $error("password changed in password mode");

	a_pw_noread: assert property (@(posedge clk) disable iff (rst)
		(pwMode && psel && !penable && !pwrite && paddr == OFF_CMD)
		|=> (prdata_ff == 32'h00000000))
		else $error("password visible in password mode");

	a_mode_busy: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_MODE_PROG && !modeSet && !badMode)
		|=> !idle [*8])
		else $error("busy missing during mode program");

	a_erase_busy: assert property (@(posedge clk) disable iff (rst)
		(start && cmd == CMD_NV_ERASE && lock_ff) |=> !idle [*8])
		else $error("busy missing during group erase");

	a_check_bit: assert property (@(posedge clk) disable iff (rst)
		(apbWr && paddr == OFF_CHECK && rangeBits_ff[pwdata[SW-1:0]])
		|=> denied_ff)
		else $error("range protected sector check passed");
endmodule

// [testbench/fsp_array_model.sv]
// Array controller model: asks the guard about a sector before changing it.
// Assumes chkProtected answers combinationally for the sector it is shown.
module fsp_array_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Bench request and guard query
	input  wire logic [2:0] reqSector,
	output logic      [2:0] chkSector,
	input  wire logic       chkProtected,
	output logic            opBlocked
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered so the bench reads a settled answer two cycles later
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			chkSector <= 3'h0;
			opBlocked <= 1'b0;
		end
		else
		begin
			chkSector <= reqSector;
			opBlocked <= chkProtected;
		end
	end
endmodule

// [testbench/tb_fsp_guard.sv]
// Self-checking bench for fsp_guard: APB tasks and command sequences.
// Assumes zero-wait APB and a shortened unlock delay of 40 cycles.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_fsp_guard
	import fsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, chkProtected, opBlocked, rerr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [2:0]  reqSector = 3'h0, chkSector;
	int          bad_count = 0, samples_checked = 0, n;
	always #2 clk = ~clk;
	fsp_guard #(.SECTORS(8), .UNLOCK_CNT(40)) dut (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chkSector(chkSector),
		.chkProtected(chkProtected));
	fsp_array_model model (.clk(clk), .rst(rst), .reqSector(reqSector),
		.chkSector(chkSector), .chkProtected(chkProtected),
		.opBlocked(opBlocked));
	// ************************************************************
	// Bus tasks
	// ************************************************************
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask
	task automatic cmd(input logic [31:0] arg, input logic [3:0] c);
		apb(1'b1, OFF_ARG, arg);
		apb(1'b1, OFF_CMD, {28'h0, c});
	endtask
	// Poll count tells how long busy stood
	task automatic idle();
		n = 0;
		do begin apb(1'b0, OFF_STATUS, 32'h0); n++; end
		while (rdat[ST_BUSY] !== 1'b0 && n < 500);
	endtask
	task automatic pw(input logic [31:0] lo, input logic [31:0] hi, input logic [3:0] c);
		apb(1'b1, OFF_PWLO, lo);
		apb(1'b1, OFF_PWHI, hi);
		cmd(32'h0, c);
	endtask
	task automatic probe(input logic [2:0] s, input logic e);
		reqSector <= s;
		repeat (3) @(posedge clk);
		@(negedge clk);
		`CHK(opBlocked, e)
	endtask
	task automatic hwreset();
		@(posedge clk) rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ************************************************************
	// Sequence
	// ************************************************************
	initial
	begin
		#100000;
		bad_count++;
		give_verdict();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_STATUS, 32'h4);
		rd(OFF_MODECFG, 32'h7);
		rd(OFF_NVBITS, 32'hFF);
		rd(OFF_CMD, 32'hFFFFFFFF);
		probe(3'h3, 1'b0);
		apb(1'b1, OFF_RANGE, 32'h8);
		rd(OFF_RANGE, 32'h8);
		probe(3'h3, 1'b1);
		apb(1'b1, OFF_CHECK, 32'h3);
		rd(OFF_STATUS, 32'h14);
		apb(1'b1, OFF_RANGE, 32'h0);
		apb(1'b1, OFF_CHECK, 32'h0);
		rd(OFF_STATUS, 32'h4);
		cmd(32'h2, CMD_VOL_WRITE);
		rd(OFF_VBITS, 32'hFB);
		probe(3'h2, 1'b1);
		cmd(32'h5, CMD_NV_PROG);
		rd(OFF_STATUS, 32'h5);
		idle();
		rd(OFF_NVBITS, 32'hDF);
		probe(3'h5, 1'b1);
		cmd(32'h0, CMD_SOFT_RST);
		rd(OFF_VBITS, 32'hFF);
		rd(OFF_STATUS, 32'h4);
		cmd(32'h0, CMD_NV_ERASE);
		idle();
		rd(OFF_NVBITS, 32'hFF);
		cmd(32'h0, CMD_LOCK_CLR);
		rd(OFF_STATUS, 32'h0);
		cmd(32'h4, CMD_NV_PROG);
		idle();
		rd(OFF_NVBITS, 32'hFF);
		rd(OFF_STATUS, 32'h2);
		hwreset();
		rd(OFF_STATUS, 32'h4);
		cmd(32'h0, CMD_MODE_PROG);
		idle();
		rd(OFF_STATUS, 32'h6);
		rd(OFF_MODECFG, 32'h7);
		pw(32'h0F0F00FF, 32'hA5A5FFFF, CMD_PW_PROG);
		idle();
		pw(32'hFFFF0F0F, 32'hFFFF5A5A, CMD_PW_PROG);
		idle();
		apb(1'b1, OFF_ARG, 32'h0);
		rd(OFF_CMD, 32'h0F0F000F);
		apb(1'b1, OFF_ARG, 32'h1);
		rd(OFF_CMD, 32'hA5A55A5A);
		cmd(32'h2, CMD_MODE_PROG);
		idle();
		rd(OFF_MODECFG, 32'h3);
		rd(OFF_STATUS, 32'h8);
		rd(OFF_CMD, 32'h0);
		cmd(32'h4, CMD_MODE_PROG);
		idle();
		rd(OFF_MODECFG, 32'h3);
		pw(32'h0F0F000F, 32'h25A55A5A, CMD_PW_UNLOCK);
		rd(OFF_STATUS, 32'hB);
		idle();
		`CHK(n >= 12, 1'b1)
		rd(OFF_STATUS, 32'hA);
		pw(32'h0F0F000F, 32'hA5A55A5A, CMD_PW_UNLOCK);
		idle();
		`CHK(n == 1, 1'b1)
		rd(OFF_STATUS, 32'hC);
		cmd(32'h6, CMD_NV_PROG);
		idle();
		rd(OFF_NVBITS, 32'hBF);
		apb(1'b0, 12'h030, 32'h0);
		`CHK(rerr, 1'b1)
		give_verdict();
	end
endmodule
